// ---- inc/qdsi_pkg.sv ----
// Shared constants and carrier types for the burst SRAM pin interface.
// Assumes one core clock that oversamples every pin, the strobes included.
package qdsi_pkg;

  localparam int QDSI_DATA_W = 36;
  localparam int QDSI_NARROW_W = 18;
  localparam int QDSI_ADDR_W = 21;
  localparam int QDSI_BEAT_W = 2;
  localparam int QDSI_BURST_LEN = 4;

  // Pipeline depth counted in strobe edges (half link cycles).
  localparam int QDSI_PIPE_LEN = 5;
  localparam int QDSI_RD_LAT_DLL = 5;
  localparam int QDSI_RD_LAT_OFF = 2;
  localparam int QDSI_WR_LAT = 2;

  // Rising true-strobe edges of acquisition before the loop counts as locked.
  localparam int QDSI_LOCK_CYCLES = 2048;
  localparam int QDSI_FIFO_DEPTH = 4;

  localparam logic [QDSI_DATA_W-1:0] QDSI_RST_DATA = 36'h0_0000_0000;
  localparam logic [QDSI_BEAT_W-1:0] QDSI_LAST_BEAT = 2'h3;

  typedef enum logic [1:0] {
    QDSI_LOOP_BYPASS = 2'b00,
    QDSI_LOOP_ACQUIRE = 2'b01,
    QDSI_LOOP_LOCKED = 2'b10
  } qdsi_loop_t;

  // Every pin sampled by the core clock travels together.
  typedef struct packed {
    logic k;
    logic k_n;
    logic rd_sel_n;
    logic wr_sel_n;
    logic loop_off_n;
    logic wide_cfg;
    logic [QDSI_ADDR_W-1:0] addr;
    logic [QDSI_DATA_W-1:0] data;
  } qdsi_pins_t;

  // One write beat on its way from the pins into the array.
  typedef struct packed {
    logic [QDSI_ADDR_W-1:0] addr;
    logic [QDSI_BEAT_W-1:0] beat;
    logic [QDSI_DATA_W-1:0] data;
  } qdsi_wbeat_t;

endpackage

// ---- core/qdsi_fifo.sv ----
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes the same clock and synchronous reset on both sides.
`timescale 1ns/1ps
module qdsi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("qdsi_fifo depth must be a power of two of at least two");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("qdsi_fifo width must be at least one");
  end

  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != FULL_CNT);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = slot_reg[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ---- core/qdsi_sram_port.sv ----
// Pin-level model of a separate-port, double-data-rate burst-of-four SRAM.
// Assumes the core clock oversamples the strobe pair many times per cycle.
//
// Function
// - Take address and selects on true strobe rise.
// - Take write data on both strobe rises.
// - Echo clocks toggle always, even when idle.
// - Echo edges aligned with read data changes.
// - Loop-disable low bypasses loop, drops lock.
// - Loop-disable high starts loop; locks after count.
// - Loop off gives one cycle read latency.
// - Valid flag marks read data, echo aligned.
// - Address ignored when neither port selected.
// - Narrow mode uses write bits 0-17 only.
// - Narrow mode drives read bits 0-17 only.
// - Read bus driven only for accepted reads.
// - Write select low registers address, starts write.
// - Read select low registers address, starts read.
// - Loop locked: first word 2.5 cycles later.
`timescale 1ns/1ps
module qdsi_sram_port
  import qdsi_pkg::*;
#(
  parameter int MEM_AW = 8,
  parameter int LOCK_CYCLES = QDSI_LOCK_CYCLES,
  parameter int FIFO_DEPTH = QDSI_FIFO_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic rd_sel_n_i,
  input wire logic wr_sel_n_i,
  input wire logic [QDSI_ADDR_W-1:0] addr_in_i,
  input wire logic [QDSI_DATA_W-1:0] write_data_in_i,
  input wire logic loop_off_n_i,
  input wire logic wide_cfg_i,
  output logic [QDSI_DATA_W-1:0] read_data_out_o,
  output logic [1:0] read_data_oe_o,
  output logic echo_strobe_pos_o,
  output logic echo_strobe_neg_o,
  output logic read_valid_flag_o,
  output logic loop_locked_o,
  output logic write_buf_ready_o
);

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
  localparam int WB_W = $bits(qdsi_wbeat_t);

  if (MEM_AW < QDSI_BEAT_W + 1 || MEM_AW > QDSI_ADDR_W + QDSI_BEAT_W) begin
    : g_bad_aw
    $error("qdsi_sram_port MEM_AW out of range");
  end
  if (LOCK_CYCLES < 1) begin : g_bad_lock
    $error("qdsi_sram_port LOCK_CYCLES must be positive");
  end

  // Narrow configuration forces the upper lanes to zero.
  function automatic logic [QDSI_DATA_W-1:0] lane_mask(
    input logic [QDSI_DATA_W-1:0] d,
    input logic wide
  );
    lane_mask = wide ? d :
      {{(QDSI_DATA_W - QDSI_NARROW_W){1'b0}}, d[QDSI_NARROW_W-1:0]};
  endfunction

  // Pin synchronisers; the first stage feeds only the second.
  qdsi_pins_t pins_meta_reg;
  qdsi_pins_t pins_sync_reg;
  qdsi_pins_t pins_now;
  logic k_hist_reg;
  logic kn_hist_reg;
  logic k_rise;
  logic kn_rise;
  logic strobe;

  assign pins_now = '{k: k_i, k_n: k_n_i, rd_sel_n: rd_sel_n_i,
                      wr_sel_n: wr_sel_n_i, loop_off_n: loop_off_n_i,
                      wide_cfg: wide_cfg_i, addr: addr_in_i,
                      data: write_data_in_i};

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      k_hist_reg <= 1'b0;
      kn_hist_reg <= 1'b0;
    end else begin
      pins_meta_reg <= pins_now;
      pins_sync_reg <= pins_meta_reg;
      k_hist_reg <= pins_sync_reg.k;
      kn_hist_reg <= pins_sync_reg.k_n;
    end
  end

  // Only rising edges count; the complement is used as its own strobe
  // rather than inferred from the true one.
  assign k_rise = pins_sync_reg.k & ~k_hist_reg;
  assign kn_rise = pins_sync_reg.k_n & ~kn_hist_reg;
  assign strobe = k_rise | kn_rise;

  // Echo clocks follow the strobes with the same two-cycle delay as the
  // read data path, so both move in the same core cycle.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      echo_strobe_pos_o <= 1'b0;
      echo_strobe_neg_o <= 1'b0;
    end else begin
      echo_strobe_pos_o <= k_hist_reg;
      echo_strobe_neg_o <= kn_hist_reg;
    end
  end

  // Delay-locked loop: reset while disabled, counts true strobe cycles.
  qdsi_loop_t loop_state_reg;
  logic [LOCK_W-1:0] lock_cnt_reg;
  logic loop_locked;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !pins_sync_reg.loop_off_n) begin
      loop_state_reg <= QDSI_LOOP_BYPASS;
      lock_cnt_reg <= '0;
    end else begin
      unique case (loop_state_reg)
        QDSI_LOOP_BYPASS: begin
          loop_state_reg <= QDSI_LOOP_ACQUIRE;
          lock_cnt_reg <= '0;
        end
        QDSI_LOOP_ACQUIRE: begin
          if (k_rise) begin
            if (lock_cnt_reg == LOCK_LAST) begin
              loop_state_reg <= QDSI_LOOP_LOCKED;
            end else begin
              lock_cnt_reg <= lock_cnt_reg + 1'b1;
            end
          end
        end
        QDSI_LOOP_LOCKED: begin
          loop_state_reg <= QDSI_LOOP_LOCKED;
        end
        default: begin
          loop_state_reg <= QDSI_LOOP_BYPASS;
        end
      endcase
    end
  end

  assign loop_locked = (loop_state_reg == QDSI_LOOP_LOCKED);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      loop_locked_o <= 1'b0;
    end else begin
      loop_locked_o <= loop_locked;
    end
  end

  // Commands are taken on true strobe rises only; the address is kept only
  // when its port is selected. Read and write pipes are independent.
  logic rd_cmd;
  logic wr_cmd;
  assign rd_cmd = k_rise & ~pins_sync_reg.rd_sel_n;
  assign wr_cmd = k_rise & ~pins_sync_reg.wr_sel_n;

  logic [QDSI_PIPE_LEN-1:0] rd_pipe_reg;
  logic [QDSI_ADDR_W-1:0] rd_addr_pipe_reg [QDSI_PIPE_LEN];
  logic [QDSI_WR_LAT-1:0] wr_pipe_reg;
  logic [QDSI_ADDR_W-1:0] wr_addr_pipe_reg [QDSI_WR_LAT];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_pipe_reg <= '0;
      wr_pipe_reg <= '0;
      for (int i = 0; i < QDSI_PIPE_LEN; i++) begin
        rd_addr_pipe_reg[i] <= '0;
      end
      for (int i = 0; i < QDSI_WR_LAT; i++) begin
        wr_addr_pipe_reg[i] <= '0;
      end
    end else if (strobe) begin
      rd_pipe_reg <= {rd_pipe_reg[QDSI_PIPE_LEN-2:0], rd_cmd};
      wr_pipe_reg <= {wr_pipe_reg[QDSI_WR_LAT-2:0], wr_cmd};
      for (int i = 1; i < QDSI_PIPE_LEN; i++) begin
        rd_addr_pipe_reg[i] <= rd_addr_pipe_reg[i-1];
      end
      for (int i = 1; i < QDSI_WR_LAT; i++) begin
        wr_addr_pipe_reg[i] <= wr_addr_pipe_reg[i-1];
      end
      if (rd_cmd) begin
        rd_addr_pipe_reg[0] <= pins_sync_reg.addr;
      end
      if (wr_cmd) begin
        wr_addr_pipe_reg[0] <= pins_sync_reg.addr;
      end
    end
  end

  // Read burst: first word five strobe edges after the command when
  // locked, two edges (one link cycle) when the loop is off.
  logic rd_start;
  logic [QDSI_ADDR_W-1:0] rd_start_addr;
  logic rd_active_reg;
  logic [QDSI_BEAT_W-1:0] rd_beat_reg;
  logic [QDSI_ADDR_W-1:0] rd_burst_addr_reg;
  logic rd_emit;
  logic [QDSI_BEAT_W-1:0] rd_cur_beat;
  logic [QDSI_ADDR_W-1:0] rd_cur_addr;

  assign rd_start = loop_locked ? rd_pipe_reg[QDSI_RD_LAT_DLL-1]
                                : rd_pipe_reg[QDSI_RD_LAT_OFF-1];
  assign rd_start_addr = loop_locked ? rd_addr_pipe_reg[QDSI_RD_LAT_DLL-1]
                                     : rd_addr_pipe_reg[QDSI_RD_LAT_OFF-1];
  assign rd_emit = rd_start | (rd_active_reg & (rd_beat_reg != QDSI_LAST_BEAT));
  assign rd_cur_beat = rd_start ? '0 : rd_beat_reg + 1'b1;
  assign rd_cur_addr = rd_start ? rd_start_addr : rd_burst_addr_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_active_reg <= 1'b0;
      rd_beat_reg <= '0;
      rd_burst_addr_reg <= '0;
    end else if (strobe) begin
      rd_active_reg <= rd_emit;
      rd_beat_reg <= rd_cur_beat;
      if (rd_start) begin
        rd_burst_addr_reg <= rd_start_addr;
      end
    end
  end

  // Write burst: first word on the true rise one cycle after the command,
  // then one word on each of the next three strobe rises.
  logic wr_start;
  logic wr_active_reg;
  logic [QDSI_BEAT_W-1:0] wr_beat_reg;
  logic [QDSI_ADDR_W-1:0] wr_burst_addr_reg;
  logic wr_emit;
  logic [QDSI_BEAT_W-1:0] wr_cur_beat;
  qdsi_wbeat_t wr_beat_word;

  assign wr_start = wr_pipe_reg[QDSI_WR_LAT-1];
  assign wr_emit = wr_start | (wr_active_reg & (wr_beat_reg != QDSI_LAST_BEAT));
  assign wr_cur_beat = wr_start ? '0 : wr_beat_reg + 1'b1;
  assign wr_beat_word.addr = wr_start ? wr_addr_pipe_reg[QDSI_WR_LAT-1]
                                      : wr_burst_addr_reg;
  assign wr_beat_word.beat = wr_cur_beat;
  assign wr_beat_word.data = lane_mask(pins_sync_reg.data,
                                       pins_sync_reg.wide_cfg);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_active_reg <= 1'b0;
      wr_beat_reg <= '0;
      wr_burst_addr_reg <= '0;
    end else if (strobe) begin
      wr_active_reg <= wr_emit;
      wr_beat_reg <= wr_cur_beat;
      if (wr_start) begin
        wr_burst_addr_reg <= wr_addr_pipe_reg[QDSI_WR_LAT-1];
      end
    end
  end

  // Write beats queue here because the array has a single port and reads
  // take it first; a beat arriving while full is lost, which the ready
  // output makes visible to the controller.
  logic mem_rd_en;
  logic fifo_in_ready;
  logic fifo_out_valid;
  qdsi_wbeat_t fifo_out;

  assign mem_rd_en = strobe & rd_emit;

  qdsi_fifo #(
    .WIDTH(WB_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .in_valid_i(strobe & wr_emit),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wr_beat_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(~mem_rd_en),
    .out_data_o(fifo_out)
  );

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      write_buf_ready_o <= 1'b1;
    end else begin
      write_buf_ready_o <= fifo_in_ready;
    end
  end

  // Storage array, one word per burst beat.
  logic [QDSI_DATA_W-1:0] mem_reg [2**MEM_AW];
  logic [QDSI_DATA_W-1:0] mem_rdata_reg;
  logic [MEM_AW-1:0] mem_waddr;
  logic [MEM_AW-1:0] mem_raddr;

  assign mem_waddr = {fifo_out.addr[MEM_AW-QDSI_BEAT_W-1:0], fifo_out.beat};
  assign mem_raddr = {rd_cur_addr[MEM_AW-QDSI_BEAT_W-1:0], rd_cur_beat};

  always_ff @(posedge ref_clk_i) begin
    if (fifo_out_valid && !mem_rd_en) begin
      mem_reg[mem_waddr] <= fifo_out.data;
    end
    if (mem_rd_en) begin
      mem_rdata_reg <= mem_reg[mem_raddr];
    end
  end

  // Output stage: updates only one cycle after a strobe edge, the same
  // cycle the echo clocks move.
  logic rd_emit_d_reg;
  logic strobe_d_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_emit_d_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
    end else begin
      rd_emit_d_reg <= mem_rd_en;
      strobe_d_reg <= strobe;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      read_data_out_o <= QDSI_RST_DATA;
      read_data_oe_o <= 2'h0;
      read_valid_flag_o <= 1'b0;
    end else if (rd_emit_d_reg) begin
      read_data_out_o <= lane_mask(mem_rdata_reg,
                                   pins_sync_reg.wide_cfg);
      read_data_oe_o <= {pins_sync_reg.wide_cfg, 1'b1};
      read_valid_flag_o <= 1'b1;
    end else if (strobe_d_reg) begin
      read_data_oe_o <= 2'h0;
      read_valid_flag_o <= 1'b0;
    end
  end

endmodule

// ---- verif/qdsi_sram_port_assertions.sv ----
// Checker for the burst SRAM pin outputs, bound into the port model.
// Assumes the far side runs the strobe pair freely and in antiphase.
`timescale 1ns/1ps
module qdsi_chk
  import qdsi_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic loop_off_n_i,
  input wire logic wide_cfg_i,
  input wire logic [QDSI_DATA_W-1:0] read_data_out_o,
  input wire logic [1:0] read_data_oe_o,
  input wire logic echo_strobe_pos_o,
  input wire logic echo_strobe_neg_o,
  input wire logic read_valid_flag_o,
  input wire logic loop_locked_o
);
  logic [3:0] still_reg;
  logic [3:0] age_reg;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Saturating counts keep the helpers small over long idle stretches.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || echo_strobe_pos_o != $past(echo_strobe_pos_o)) begin
      still_reg <= 4'h0;
    end else if (still_reg != 4'hF) begin
      still_reg <= still_reg + 4'h1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      age_reg <= 4'h0;
    end else if (age_reg != 4'h8) begin
      age_reg <= age_reg + 4'h1;
    end
  end
  oe_tracks_valid_a: assert property (
    (read_data_oe_o != 2'b00) == read_valid_flag_o)
    else $error("output enable and valid flag disagree");
  narrow_lane_a: assert property (
    read_valid_flag_o && !wide_cfg_i |-> read_data_oe_o == 2'b01
    && read_data_out_o[35:18] == 18'h0_0000)
    else $error("narrow mode drives upper lane");
  wide_lane_a: assert property (
    read_valid_flag_o && wide_cfg_i |-> read_data_oe_o == 2'b11)
    else $error("wide mode lane not enabled");
  valid_edge_a: assert property (
    read_valid_flag_o != $past(read_valid_flag_o)
    |-> echo_strobe_pos_o != $past(echo_strobe_pos_o))
    else $error("valid flag moved off an echo edge");
  data_edge_a: assert property (
    read_valid_flag_o && read_data_out_o != $past(read_data_out_o)
    |-> echo_strobe_pos_o != $past(echo_strobe_pos_o))
    else $error("read data moved off an echo edge");
  echo_runs_a: assert property (still_reg <= 4'h8)
    else $error("echo strobe stopped");
  echo_pair_a: assert property (
    age_reg == 4'h8 |-> echo_strobe_neg_o != echo_strobe_pos_o)
    else $error("echo strobes not complementary");
  bypass_unlock_a: assert property (
    !loop_off_n_i [*6] |-> !loop_locked_o)
    else $error("lock kept while loop bypassed");
  lock_wait_a: assert property (
    !loop_off_n_i [*6] ##1 loop_off_n_i |-> !loop_locked_o [*8])
    else $error("lock reported too early");
  cover property ($rose(read_valid_flag_o) && wide_cfg_i);
  cover property ($rose(read_valid_flag_o) && !wide_cfg_i);
  cover property ($rose(loop_locked_o));
endmodule

bind qdsi_sram_port qdsi_chk qdsi_chk_inst (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .loop_off_n_i(loop_off_n_i), .wide_cfg_i(wide_cfg_i),
  .read_data_out_o(read_data_out_o), .read_data_oe_o(read_data_oe_o),
  .echo_strobe_pos_o(echo_strobe_pos_o),
  .echo_strobe_neg_o(echo_strobe_neg_o),
  .read_valid_flag_o(read_valid_flag_o), .loop_locked_o(loop_locked_o)
);

// ---- verif/qdsi_ctrl_model.sv ----
// Memory controller model: free strobe pair, commands and write beats.
// Assumes go requests are held until a complementary strobe rise.
`timescale 1ns/1ps
module qdsi_ctrl_model
  import qdsi_pkg::*;
(
  input wire logic rd_go_i,
  input wire logic wr_go_i,
  input wire logic [QDSI_ADDR_W-1:0] addr_i,
  input wire logic [3:0][QDSI_DATA_W-1:0] wdata_i,
  output logic k_o,
  output logic k_n_o,
  output logic rd_sel_n_o,
  output logic wr_sel_n_o,
  output logic [QDSI_ADDR_W-1:0] addr_o,
  output logic [QDSI_DATA_W-1:0] data_o
);
  logic [3:0][QDSI_DATA_W-1:0] wbuf;
  int wcnt;
  initial begin
    k_o = 1'b0;
    rd_sel_n_o = 1'b1;
    wr_sel_n_o = 1'b1;
    addr_o = '0;
    data_o = '0;
    wcnt = 0;
    #7;
    forever #160 k_o = ~k_o;
  end
  assign k_n_o = ~k_o;
  // Selects move on the true strobe fall, half a cycle before sampling.
  // Data move midway between strobe edges, because a word that changed on
  // a strobe edge would reach the core together with that edge.
  always @(k_o) begin
    if (wcnt >= 2 && wcnt <= 5) begin
      data_o <= #80 wbuf[wcnt-2];
    end else begin
      data_o <= #80 ~data_o;
    end
    wcnt <= (wcnt == 0 || wcnt == 5) ? 0 : wcnt + 1;
    if (!k_o) begin
      rd_sel_n_o <= !rd_go_i;
      wr_sel_n_o <= !wr_go_i;
      addr_o <= (rd_go_i || wr_go_i) ? addr_i : ~addr_o;
      if (wr_go_i) begin
        wbuf <= wdata_i;
        wcnt <= 1;
      end
    end
  end
endmodule

// ---- verif/test_quad_port_ddr_sram_interface.sv ----
// Self-checking bench for the burst SRAM pin interface.
// Assumes the controller model makes the strobes and command pins.
`timescale 1ns/1ps
module test_quad_port_ddr_sram_interface import qdsi_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic loop_off_n = 1'b0;
  logic wide_cfg = 1'b1;
  logic rd_go = 1'b0;
  logic wr_go = 1'b0;
  logic [QDSI_ADDR_W-1:0] addr = '0;
  logic [3:0][QDSI_DATA_W-1:0] wdat = '0;
  logic k, k_n, rd_sel_n, wr_sel_n, echo_pos, echo_neg, rvalid, locked;
  logic buf_rdy;
  logic [QDSI_ADDR_W-1:0] pin_addr;
  logic [QDSI_DATA_W-1:0] pin_data, rdata;
  logic [1:0] oe;
  int error_cnt = 0;
  int compares = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  qdsi_ctrl_model qdsi_ctrl_model_inst (.rd_go_i(rd_go), .wr_go_i(wr_go),
    .addr_i(addr), .wdata_i(wdat), .k_o(k), .k_n_o(k_n),
    .rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n), .addr_o(pin_addr),
    .data_o(pin_data));
  qdsi_sram_port #(.LOCK_CYCLES(4)) qdsi_sram_port_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .k_i(k), .k_n_i(k_n),
    .rd_sel_n_i(rd_sel_n), .wr_sel_n_i(wr_sel_n), .addr_in_i(pin_addr),
    .write_data_in_i(pin_data), .loop_off_n_i(loop_off_n),
    .wide_cfg_i(wide_cfg), .read_data_out_o(rdata), .read_data_oe_o(oe),
    .echo_strobe_pos_o(echo_pos), .echo_strobe_neg_o(echo_neg),
    .read_valid_flag_o(rvalid), .loop_locked_o(locked),
    .write_buf_ready_o(buf_rdy));
  task automatic chk(input string what, input logic [35:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [3:0][35:0] mk(input logic [35:0] b);
    for (int i = 0; i < 4; i++) mk[i] = b ^ 36'(i);
  endfunction
  // One command cycle, read, write or both, sampled per call, on a single strobe fall; callers wait out each burst before the next.
  task automatic cmd(input logic r, w, input logic [20:0] a,
                     input logic [3:0][35:0] d);
    @(posedge ref_clk_i);
    rd_go <= r;
    wr_go <= w;
    addr <= a;
    wdat <= d;
    @(negedge k);
    @(posedge ref_clk_i);
    rd_go <= 1'b0;
    wr_go <= 1'b0;
  endtask
  task automatic wr(input logic [20:0] a, input logic [35:0] b);
    cmd(1'b0, 1'b1, a, mk(b));
    repeat (32) @(posedge ref_clk_i);
  endtask
  task automatic collect(input int lat, input logic [35:0] b,
                         input logic dchk);
    int n, i, t;
    logic p;
    logic [35:0] m;
    logic [3:0][35:0] w;
    n = 0;
    i = 0;
    w = mk(b);
    m = wide_cfg ? 36'hF_FFFF_FFFF : 36'h0_0003_FFFF;
    @(posedge k);
    p = echo_pos;
    for (t = 0; t < 80 && i < 5; t++) begin
      @(posedge ref_clk_i);
      #1;
      if (echo_pos !== p) begin
        p = echo_pos;
        n++;
        if (i == 4) begin
          chk("valid_end", 36'(rvalid), 36'h0);
          chk("oe_end", 36'(oe), 36'h0);
          i++;
        end else if (rvalid === 1'b1) begin
          if (i == 0) chk("latency", 36'(n), 36'(lat + 1));
          if (dchk) chk("word", rdata, w[i] & m);
          chk("oe", 36'(oe), wide_cfg ? 36'h3 : 36'h1);
          i++;
        end
      end
    end
    chk("burst_done", 36'(i), 36'h5);
    if (i < 5) give_verdict();
  endtask
  task automatic rd(input int lat, input logic [20:0] a,
                    input logic [35:0] b);
    cmd(1'b1, 1'b0, a, '0);
    collect(lat, b, 1'b1);
  endtask
  task automatic lock_to(input logic v);
    int t;
    for (t = 0; t < 300 && locked !== v; t++) @(posedge ref_clk_i);
    chk("lock_state", 36'(locked), 36'(v));
    if (v) chk("lock_time", 36'(t >= 24), 36'h1);
    if (locked !== v) give_verdict();
  endtask
  task automatic t_off();
    wr(21'h00_0010, 36'h1_2345_6780);
    rd(2, 21'h00_0010, 36'h1_2345_6780);
    chk("off_unlocked", 36'(locked), 36'h0);
    $display("t_off done");
  endtask
  task automatic t_lock();
    @(posedge ref_clk_i) loop_off_n <= 1'b1;
    lock_to(1'b1);
    rd(5, 21'h00_0010, 36'h1_2345_6780);
    $display("t_lock done");
  endtask
  task automatic t_both();
    cmd(1'b1, 1'b1, 21'h00_0010, mk(36'h0_ABCD_0000));
    collect(5, 36'h0, 1'b0);
    repeat (16) @(posedge ref_clk_i);
    rd(5, 21'h00_0010, 36'h0_ABCD_0000);
    $display("t_both done");
  endtask
  task automatic t_narrow();
    @(posedge ref_clk_i) wide_cfg <= 1'b0;
    wr(21'h00_0024, 36'hF_FFF5_5550);
    rd(5, 21'h00_0024, 36'hF_FFF5_5550);
    $display("t_narrow done");
  endtask
  task automatic t_bypass();
    @(posedge ref_clk_i) loop_off_n <= 1'b0;
    lock_to(1'b0);
    repeat (40) @(posedge ref_clk_i);
    rd(2, 21'h00_0024, 36'hF_FFF5_5550);
    $display("t_bypass done");
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("rst_valid", 36'(rvalid), 36'h0);
    chk("rst_buf_ready", 36'(buf_rdy), 36'h1);
    repeat (4) @(posedge ref_clk_i);
    t_off();
    t_lock();
    t_both();
    t_narrow();
    t_bypass();
    give_verdict();
  end
endmodule
